// File: hw/ufp_pkg.sv
// Constants, register map and channel kind encodings of the five-stage
// underfrequency protection block.
// Assumes a 125 MHz system clock and a measurement front end that delivers
// frequency in mHz and voltage magnitude in thousandths of rated voltage.
//
// Behaviour
// RULE1: Five independent definite-time stages, each with its own enable.
// RULE2: One to three phase-earth or phase-phase signals from one channel.
// RULE3: A stage evaluates only signals above its undervoltage level.
// RULE4: Pickup needs every evaluated signal to meet the condition at once.
// RULE5: A stage picks up when frequency falls below its threshold.
// RULE6: Picked up, it holds until frequency exceeds threshold plus 20 mHz.
// RULE7: Threshold is per unit, scaled by rated frequency of 50 or 60 Hz.
// RULE8: Threshold may lie below or above rated frequency; no ordering check.
// RULE9: Trip once pickup persists for the stage delay; both reported apart.
// RULE10: A zero delay trips together with pickup.
// RULE11: Pickup, trip and timing clear at once above the reset level.
// RULE12: Stage block input or general block inhibits pickup and trip.
// RULE13: Undervoltage block needs every available signal below its level.
// RULE14: Undervoltage block clears an existing pickup immediately.
// RULE15: Any blocking cause raises the stage blocked output.
// RULE16: Undervoltage block also raises its own per-stage output.
// RULE17: No channel assigned gives health alarm and suppresses all stages.
// RULE18: Neutral channel: alarm and suppression; otherwise health is normal.
// RULE19: Threshold spans 0.8 to 1.2 per unit, default 0.95.
// RULE20: Trip delay spans 0 to 120000 ms, default 200 ms.
// RULE21: UV level spans 0.15 to 1.0 pu, default 0.8; enable defaults off.
// RULE22: A disabled stage keeps all its outputs low and its timer cleared.
// RULE23: Delay counts millisecond clock ticks, restarting on each pickup.

package ufp_pkg;
    localparam int NUM_STAGES = 5;
    localparam int NUM_SIG = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_IN_NS = 1000000;
    localparam int CYC_PER_MS_DEF = MS_IN_NS / CLK_PERIOD_NS;
    // Frequency settings, threshold in thousandths of rated frequency
    localparam logic [17:0] RATED_HZ_50 = 18'h00032;
    localparam logic [17:0] RATED_HZ_60 = 18'h0003C;
    localparam logic [17:0] HYST_MHZ = 18'h00014;
    localparam logic [10:0] THR_MIN = 11'h320;
    localparam logic [10:0] THR_MAX = 11'h4B0;
    localparam logic [10:0] THR_RST = 11'h3B6;
    localparam logic [16:0] DLY_MAX = 17'h1D4C0;
    localparam logic [16:0] DLY_RST = 17'h000C8;
    localparam logic [9:0] UVL_MIN = 10'h096;
    localparam logic [9:0] UVL_MAX = 10'h3E8;
    localparam logic [9:0] UVL_RST = 10'h320;
    // Register map (byte addresses)
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [3:0] STG_FIRST_BLK = 4'h1;
    localparam logic [3:0] STG_OFS_CFG = 4'h0;
    localparam logic [3:0] STG_OFS_DLY = 4'h4;
    localparam logic [3:0] STG_OFS_UVL = 4'h8;
    // Field positions
    localparam int CTRL_RATED60_BIT = 0;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_AVAIL_LSB = 8;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_THR_LSB = 16;
    localparam int STS_START_LSB = 0;
    localparam int STS_TRIP_LSB = 8;
    localparam int STS_BLK_LSB = 16;
    localparam int STS_UVB_LSB = 24;
    localparam int STS_ALARM_BIT = 31;
    // Channel kinds
    typedef enum logic [1:0] {
        UFP_CH_NONE = 2'h0,
        UFP_CH_PH_EARTH = 2'h1,
        UFP_CH_PH_PHASE = 2'h3,
        UFP_CH_NEUTRAL = 2'h2
    } ufp_chan_t;
endpackage

// File: hw/ufp_stages.sv
// Five-stage underfrequency protection with a classic Wishbone slave.
// Measurement inputs come from logic on clk_sys; block inputs are pins
// from another domain and are filtered here.
`timescale 1ns/1ns
`default_nettype none

module ufp_stages
    import ufp_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0][16:0] meas_freq_mhz,
    input wire logic [2:0][15:0] meas_volt_mpu,
    input wire logic [4:0] stage_block_in,
    input wire logic block_in,
    output logic [4:0] stage_start_flag,
    output logic [4:0] stage_trip_flag,
    output logic [4:0] stage_blocked_flag,
    output logic [4:0] stage_uv_blocked_flag,
    output logic health_alarm
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic rated_60;
        logic [1:0] chan_kind;
        logic [2:0] chan_avail;
        logic [4:0] en;
        logic [4:0][10:0] thr;
        logic [4:0][16:0] dly;
        logic [4:0][9:0] uvl;
        logic [4:0][16:0] cyc;
        logic [4:0][16:0] ms;
        logic [4:0] start;
        logic [4:0] trip;
        logic [4:0] blk;
        logic [4:0] uvb;
        logic alarm;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] sync3;
        logic [5:0] blk_f;
    } ufp_state_t;

    ufp_state_t st_q;
    ufp_state_t st_d;

    logic alarm_now;
    logic [2:0] avail;
    logic [17:0] rated_hz;
    logic [4:0][2:0] ev;
    logic [4:0][2:0] meet;
    logic [4:0][2:0] vlow;
    logic [4:0] uv_act;

    // Health: a missing or neutral channel disables every stage
    assign alarm_now = (st_q.chan_kind == UFP_CH_NONE) ||
                       (st_q.chan_kind == UFP_CH_NEUTRAL); // RULE17 RULE18
    // Only signals the channel really carries take part
    assign avail = alarm_now ? 3'h0 : st_q.chan_avail; // RULE2
    assign rated_hz = st_q.rated_60 ? RATED_HZ_60 : RATED_HZ_50;

    // Per-stage, per-signal evaluation of voltage and frequency
    genvar s, j;
    generate
        for (s = 0; s < NUM_STAGES; s++)
        begin : g_stage
            logic [17:0] fop;
            logic [17:0] frel;
            // Per unit times rated Hz gives mHz directly; no ordering
            // against rated frequency is imposed
            assign fop = 18'(st_q.thr[s]) * rated_hz; // RULE7 RULE8
            assign frel = fop + HYST_MHZ; // RULE6
            for (j = 0; j < NUM_SIG; j++)
            begin : g_sig
                assign ev[s][j] = avail[j] &&
                    (meas_volt_mpu[j] > {6'h00, st_q.uvl[s]}); // RULE3
                assign vlow[s][j] = !avail[j] ||
                    (meas_volt_mpu[j] < {6'h00, st_q.uvl[s]}); // RULE13
                // Pick up below threshold, drop out only above hysteresis
                assign meet[s][j] = !ev[s][j] || (st_q.start[s] ?
                    ({1'b0, meas_freq_mhz[j]} <= frel) :
                    ({1'b0, meas_freq_mhz[j]} < fop)); // RULE5 RULE6 RULE11
            end
            assign uv_act[s] = (|avail) && (&vlow[s]); // RULE13
        end
    endgenerate

    // Saturate a setting into its allowed span
    function automatic logic [16:0] clamp17(input logic [16:0] v,
        input logic [16:0] lo, input logic [16:0] hi);
        logic [16:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction

    // Byte-lane merge of a write into an existing register image
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Next state: bus slave, pin filters and the five stages
    always_comb
    begin
        logic [31:0] img;
        logic [31:0] wv;
        logic [3:0] blkn;
        logic [2:0] sidx;
        logic op;
        logic hit_stage;
        img = 32'h00000000;
        wv = 32'h00000000;
        blkn = wb_adr_i[7:4];
        sidx = 3'(blkn - STG_FIRST_BLK);
        op = 1'b0;
        hit_stage = (blkn >= STG_FIRST_BLK) &&
                    (blkn < STG_FIRST_BLK + 4'(NUM_STAGES));
        st_d = st_q;

        // Current image of the addressed register; unmapped reads zero
        if (wb_adr_i == ADR_CTRL)
        begin
            img[CTRL_RATED60_BIT] = st_q.rated_60;
            img[CTRL_KIND_LSB +: 2] = st_q.chan_kind;
            img[CTRL_AVAIL_LSB +: 3] = st_q.chan_avail;
        end
        else if (wb_adr_i == ADR_STATUS)
        begin
            img[STS_START_LSB +: 5] = st_q.start;
            img[STS_TRIP_LSB +: 5] = st_q.trip;
            img[STS_BLK_LSB +: 5] = st_q.blk;
            img[STS_UVB_LSB +: 5] = st_q.uvb;
            img[STS_ALARM_BIT] = st_q.alarm;
        end
        else if (hit_stage && wb_adr_i[3:0] == STG_OFS_CFG)
        begin
            img[CFG_EN_BIT] = st_q.en[sidx];
            img[CFG_THR_LSB +: 11] = st_q.thr[sidx];
        end
        else if (hit_stage && wb_adr_i[3:0] == STG_OFS_DLY)
        begin
            img[16:0] = st_q.dly[sidx];
        end
        else if (hit_stage && wb_adr_i[3:0] == STG_OFS_UVL)
        begin
            img[9:0] = st_q.uvl[sidx];
        end
        wv = merge(img, wb_dat_i, wb_sel_i);

        // Ack one cycle after the request, dropped the cycle after
        st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
        if (!st_q.ack)
        begin
            st_d.rdata = img;
        end

        // Write lands on the edge where ack is sampled high
        if (st_q.ack && wb_cyc_i && wb_stb_i && wb_we_i)
        begin
            if (wb_adr_i == ADR_CTRL)
            begin
                st_d.rated_60 = wv[CTRL_RATED60_BIT];
                st_d.chan_kind = wv[CTRL_KIND_LSB +: 2];
                st_d.chan_avail = wv[CTRL_AVAIL_LSB +: 3];
            end
            else if (hit_stage && wb_adr_i[3:0] == STG_OFS_CFG)
            begin
                st_d.en[sidx] = wv[CFG_EN_BIT];
                st_d.thr[sidx] = 11'(clamp17(17'(wv[CFG_THR_LSB +: 11]),
                    17'(THR_MIN), 17'(THR_MAX))); // RULE19
            end
            else if (hit_stage && wb_adr_i[3:0] == STG_OFS_DLY)
            begin
                st_d.dly[sidx] = clamp17(wv[16:0], 17'h00000,
                    DLY_MAX); // RULE20
            end
            else if (hit_stage && wb_adr_i[3:0] == STG_OFS_UVL)
            begin
                st_d.uvl[sidx] = 10'(clamp17(17'(wv[9:0]),
                    17'(UVL_MIN), 17'(UVL_MAX))); // RULE21
            end
        end

        // Block pins: a change counts once stages two and three agree
        st_d.sync1 = {block_in, stage_block_in};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int b = 0; b < 6; b++)
        begin
            if (st_q.sync2[b] == st_q.sync3[b])
            begin
                st_d.blk_f[b] = st_q.sync3[b];
            end
        end

        st_d.alarm = alarm_now; // RULE17 RULE18

        // Stage decisions; each stage runs independently
        for (int k = 0; k < NUM_STAGES; k++)
        begin
            op = st_q.en[k] && !alarm_now; // RULE1 RULE22 RULE17
            st_d.uvb[k] = op && uv_act[k]; // RULE16
            st_d.blk[k] = op && (st_q.blk_f[k] || st_q.blk_f[NUM_STAGES] ||
                uv_act[k]); // RULE12 RULE15
            // Undervoltage block drops a live pickup in the same step
            st_d.start[k] = op && !st_d.blk[k] && (|ev[k]) &&
                (&meet[k]); // RULE4 RULE14
            if (st_d.start[k] && st_q.start[k])
            begin
                // Millisecond ticks from clk_sys, saturating
                if (st_q.cyc[k] == 17'(CYC_PER_MS - 1))
                begin
                    st_d.cyc[k] = 17'h00000;
                    if (st_q.ms[k] != 17'h1FFFF)
                    begin
                        st_d.ms[k] = st_q.ms[k] + 17'h00001; // RULE23
                    end
                end
                else
                begin
                    st_d.cyc[k] = st_q.cyc[k] + 17'h00001;
                end
            end
            else
            begin
                // New pickup starts timing from zero; reset is instant
                st_d.cyc[k] = 17'h00000; // RULE11 RULE23 RULE22
                st_d.ms[k] = 17'h00000;
            end
            st_d.trip[k] = st_d.start[k] && ((st_q.dly[k] == 17'h00000) ||
                (st_q.start[k] && st_q.ms[k] >= st_q.dly[k])); // RULE9 RULE10
        end
    end

    // State register; settings come up at their defaults
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            for (int k = 0; k < NUM_STAGES; k++)
            begin
                st_q.thr[k] <= THR_RST; // RULE19
                st_q.dly[k] <= DLY_RST; // RULE20
                st_q.uvl[k] <= UVL_RST; // RULE21
            end
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o = st_q.rdata;
    assign wb_ack_o = st_q.ack;
    assign stage_start_flag = st_q.start;
    assign stage_trip_flag = st_q.trip;
    assign stage_blocked_flag = st_q.blk;
    assign stage_uv_blocked_flag = st_q.uvb;
    assign health_alarm = st_q.alarm;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    AST_HEALTH: assert property ( // RULE17
        (st_q.chan_kind == UFP_CH_NONE || st_q.chan_kind == UFP_CH_NEUTRAL)
        |=> health_alarm && stage_start_flag == 5'h00)
        else $error("health alarm or suppression missing");
    AST_OFF_QUIET: assert property ( // RULE22
        ((stage_start_flag | stage_trip_flag | stage_blocked_flag |
          stage_uv_blocked_flag) & ~$past(st_q.en)) == 5'h00)
        else $error("disabled stage shows an output");
    AST_BLOCK_INHIBIT: assert property ( // RULE12
        ((stage_start_flag | stage_trip_flag) & stage_blocked_flag) == 5'h00)
        else $error("blocked stage picked up or tripped");
    AST_TRIP_NEEDS_START: assert property ( // RULE9
        (stage_trip_flag & ~stage_start_flag) == 5'h00)
        else $error("trip without pickup");
    AST_ZERO_DELAY: assert property ( // RULE10
        $rose(stage_start_flag[0]) && $past(st_q.dly[0]) == 17'h00000
        |-> stage_trip_flag[0])
        else $error("zero delay did not trip with pickup");
    AST_DELAY_WAIT: assert property ( // RULE9
        $rose(stage_start_flag[0]) && $past(st_q.dly[0]) != 17'h00000
        |-> !stage_trip_flag[0])
        else $error("trip came before the delay");
    AST_UV_IS_BLOCK: assert property ( // RULE15
        (stage_uv_blocked_flag & ~stage_blocked_flag) == 5'h00)
        else $error("undervoltage block not shown as blocked");
    AST_UV_CLEARS: assert property ( // RULE14
        $rose(stage_uv_blocked_flag[0]) |-> !stage_start_flag[0])
        else $error("pickup survived undervoltage block");
    AST_THR_SPAN: assert property ( // RULE19
        st_q.thr[0] >= THR_MIN && st_q.thr[0] <= THR_MAX)
        else $error("threshold out of span");
    AST_WB_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");

    // Health returns to normal with a valid channel kind
    AST_ALARM_CLEAR: assert property ( // RULE18
        (st_q.chan_kind == UFP_CH_PH_EARTH ||
         st_q.chan_kind == UFP_CH_PH_PHASE)
        |=> !health_alarm)
        else $error("health alarm with a valid channel");
    // A pickup needs at least one signal that was evaluated
    AST_EVAL_NEEDED: assert property ( // RULE3
        stage_start_flag[0] |-> $past(|ev[0]))
        else $error("pickup with no evaluated signal");
    // One signal outside the dropout band ends pickup and trip at once
    AST_DROPOUT: assert property ( // RULE11
        st_q.start[0] && !(&meet[0])
        |=> !stage_start_flag[0] && !stage_trip_flag[0])
        else $error("stage held past its reset level");
    // Every available signal must be low before the block acts
    AST_UV_NEEDS_ALL: assert property ( // RULE13
        stage_uv_blocked_flag[0] |-> $past(&vlow[0] && (|avail)))
        else $error("undervoltage block with a healthy signal");
    AST_UV_FLAG: assert property ( // RULE16
        st_q.en[0] && !alarm_now && uv_act[0] |=> stage_uv_blocked_flag[0])
        else $error("undervoltage block not flagged");
    // The general pin blocks every enabled stage
    AST_GEN_BLOCK: assert property ( // RULE12
        st_q.blk_f[NUM_STAGES] && st_q.en[0] && !alarm_now
        |=> stage_blocked_flag[0] && !stage_start_flag[0])
        else $error("general block ignored");
    // A fresh pickup always times from zero
    AST_TIMER_START: assert property ( // RULE23
        $rose(stage_start_flag[0])
        |-> st_q.ms[0] == 17'h00000 && st_q.cyc[0] == 17'h00000)
        else $error("timer did not restart on pickup");
    // Clamped settings never leave their spans
    AST_DLY_SPAN: assert property ( // RULE20
        st_q.dly[0] <= DLY_MAX)
        else $error("delay out of span");
    AST_UVL_SPAN: assert property ( // RULE21
        st_q.uvl[0] >= UVL_MIN && st_q.uvl[0] <= UVL_MAX)
        else $error("undervoltage level out of span");

endmodule // ufp_stages

`default_nettype wire

// File: test/ufp_meas_model.sv
// Measurement front end model: registers the frequency and magnitude
// values that the bench sets and presents them on clk_sys.
// Assumes the bench drives the set values at the rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module ufp_meas_model
(
    input wire logic clk_sys,
    input wire logic [2:0][16:0] f_set,
    input wire logic [2:0][15:0] v_set,
    output logic [2:0][16:0] meas_freq_mhz,
    output logic [2:0][15:0] meas_volt_mpu
);
    // One register stage, as a real filter chain would add latency
    always_ff @(posedge clk_sys)
    begin
        meas_freq_mhz <= f_set;
        meas_volt_mpu <= v_set;
    end
endmodule // ufp_meas_model

`default_nettype wire

// File: test/underfrequency_protection_stages_bench.sv
// Self-checking bench of the five-stage underfrequency block.
// Assumes CYC_PER_MS of 10, so one millisecond tick is ten clocks.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end

module underfrequency_protection_stages_bench;
    import ufp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b, cyc, stb, we, bi, ack, alarm;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0][16:0] f_set, mf;
    logic [2:0][15:0] v_set, mv;
    logic [4:0] sbi, st, tr, bl, uvb;
    int mismatches = 0;
    int n_checks = 0;
    int k;

    always #4 clk_sys = ~clk_sys;

    ufp_meas_model i_meas (.clk_sys(clk_sys), .f_set(f_set), .v_set(v_set),
        .meas_freq_mhz(mf), .meas_volt_mpu(mv));

    ufp_stages #(.CYC_PER_MS(10)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .meas_freq_mhz(mf), .meas_volt_mpu(mv), .stage_block_in(sbi),
        .block_in(bi), .stage_start_flag(st), .stage_trip_flag(tr),
        .stage_blocked_flag(bl), .stage_uv_blocked_flag(uvb),
        .health_alarm(alarm));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Classic single cycle; holds the request until ack is seen high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
        settle(1);
    endtask

    task automatic meas(input logic [16:0] f0, f1, f2,
                        input logic [15:0] v0, v1, v2);
        @(posedge clk_sys);
        f_set <= {f2, f1, f0};
        v_set <= {v2, v1, v0};
        settle(3);
    endtask

    // Reset values, read-only status and an unmapped hole
    task automatic t_defaults();
        wb(1'b0, 8'h10, 32'h0, q);
        `CHK(q, 32'h03B6_0000)
        wb(1'b0, 8'h54, 32'h0, q);
        `CHK(q, 32'h0000_00C8)
        wb(1'b0, 8'h38, 32'h0, q);
        `CHK(q, 32'h0000_0320)
        wb(1'b0, 8'h0C, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        wr(8'h04, 32'hFFFF_FFFF);
        wb(1'b0, 8'h04, 32'h0, q);
        `CHK(q, 32'h8000_0000)
        $display("defaults done");
    endtask

    // Channel kind decides health
    task automatic t_health();
        `CHK(alarm, 1'b1)
        wr(8'h00, 32'h0000_0720);
        `CHK(alarm, 1'b1)
        wr(8'h00, 32'h0000_0710);
        `CHK(alarm, 1'b0)
        $display("health done");
    endtask

    // Pickup, delayed trip, dropout band and timer restart
    task automatic t_pickup();
        wr(8'h10, 32'h03B6_0001);
        wr(8'h14, 32'h0000_0002);
        meas(17'd47499, 17'd47499, 17'd47499, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st, 5'h01)
        `CHK(tr, 5'h00)
        `CHK(bl | uvb, 5'h00)
        for (k = 0; k < 100 && tr[0] !== 1'b1; k++)
            settle(1);
        `CHK(k >= 15 && k <= 21, 1'b1)
        `CHK(tr, 5'h01)
        if (tr[0] !== 1'b1)
            wrap_up();
        meas(17'd47520, 17'd47520, 17'd47520, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st[0], 1'b1)
        meas(17'd47521, 17'd47521, 17'd47521, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st | tr, 5'h00)
        meas(17'd47499, 17'd47499, 17'd47499, 16'd1000, 16'd1000, 16'd1000);
        `CHK(tr[0], 1'b0)
        wr(8'h00, 32'h0000_0000);
        `CHK(st, 5'h00)
        wr(8'h00, 32'h0000_0710);
        $display("pickup done");
    endtask

    // One signal above threshold vetoes unless its magnitude is too low
    task automatic t_signals();
        meas(17'd47499, 17'd48000, 17'd47499, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st[0], 1'b0)
        meas(17'd47499, 17'd48000, 17'd47499, 16'd1000, 16'd800, 16'd1000);
        `CHK(st[0], 1'b1)
        `CHK(uvb[0], 1'b0)
        meas(17'd47499, 17'd47499, 17'd47499, 16'd799, 16'd799, 16'd799);
        `CHK(st[0], 1'b0)
        `CHK(uvb[0], 1'b1)
        `CHK(bl[0], 1'b1)
        $display("signals done");
    endtask

    // Stage pin and general pin, through the pin synchroniser
    task automatic t_block();
        meas(17'd47499, 17'd47499, 17'd47499, 16'd1000, 16'd1000, 16'd1000);
        @(posedge clk_sys);
        sbi <= 5'h01;
        settle(5);
        `CHK({st[0], bl[0]}, 2'b01)
        @(posedge clk_sys);
        sbi <= 5'h00;
        bi <= 1'b1;
        settle(5);
        `CHK({st[0], tr[0], bl[0]}, 3'b001)
        @(posedge clk_sys);
        bi <= 1'b0;
        settle(5);
        `CHK({st[0], bl[0]}, 2'b10)
        $display("block done");
    endtask

    // Zero delay, rated frequency, high threshold, stage independence
    task automatic t_modes();
        wr(8'h14, 32'h0000_0000);
        meas(17'd47521, 17'd47521, 17'd47521, 16'd1000, 16'd1000, 16'd1000);
        meas(17'd47499, 17'd47499, 17'd47499, 16'd1000, 16'd1000, 16'd1000);
        `CHK({st[0], tr[0]}, 2'b11)
        wr(8'h00, 32'h0000_0711);
        meas(17'd56999, 17'd56999, 17'd56999, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st[0], 1'b1)
        meas(17'd57100, 17'd57100, 17'd57100, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st[0], 1'b0)
        wr(8'h00, 32'h0000_0710);
        wr(8'h10, 32'h044C_0001);
        meas(17'd54999, 17'd54999, 17'd54999, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st[0], 1'b1)
        wr(8'h50, 32'h0320_0001);
        `CHK(st, 5'h01)
        meas(17'd39999, 17'd39999, 17'd39999, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st, 5'h11)
        $display("modes done");
    endtask

    // Absent signals take no part in pickup or in the undervoltage block
    task automatic t_mask();
        wr(8'h00, 32'h0000_0330);
        `CHK(alarm, 1'b0)
        meas(17'd39999, 17'd39999, 17'd60000, 16'd1000, 16'd1000, 16'd1000);
        `CHK(st, 5'h11)
        meas(17'd39999, 17'd39999, 17'd60000, 16'd700, 16'd700, 16'd1000);
        `CHK(uvb, 5'h11)
        `CHK(st, 5'h00)
        $display("mask done");
    endtask

    // Stimulus sequence, ending in the single verdict
    initial
    begin
        rst_b = 1'b0;
        {cyc, stb, we, bi} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        sbi = 5'h00;
        f_set = {3{17'd50000}};
        v_set = {3{16'd1000}};
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        settle(2);
        t_defaults();
        t_health();
        t_pickup();
        t_signals();
        t_block();
        t_modes();
        t_mask();
        wrap_up();
    end
endmodule // underfrequency_protection_stages_bench

`default_nettype wire
